/* rtl/crfs_pkg.sv */
// Purpose: shared constants of the receive flag and bus state block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, data in the low byte
// Notes: bus state codes are two-bit fields reported in the flag register
package crfs_pkg;
	localparam logic [3:0] CRFS_OFF_FLAGS = 4'h0;
	localparam logic [3:0] CRFS_OFF_ENABLES = 4'h4;
	localparam logic [3:0] CRFS_OFF_CONTROL = 4'h8;
	localparam logic [3:0] CRFS_OFF_STATUS = 4'hc;

	localparam int CRFS_WAKE_BIT = 7;
	localparam int CRFS_CHANGE_BIT = 6;
	localparam int CRFS_RX_LSB = 4;
	localparam int CRFS_TX_LSB = 2;
	localparam int CRFS_CTL_INIT_BIT = 0;
	localparam int CRFS_CTL_WAKE_EN_BIT = 1;
	localparam int CRFS_STS_ACK_BIT = 0;
	localparam int CRFS_STS_SLEEP_BIT = 1;
	localparam int CRFS_NUM_FLAGS = 2;

	localparam logic [1:0] CRFS_ENABLES_RESET = 2'h0;
	localparam logic [1:0] CRFS_CONTROL_RESET = 2'h0;
	localparam logic [1:0] CRFS_STATE_RESET = 2'h0;

	localparam logic [1:0] CRFS_ST_OK = 2'h0;
	localparam logic [1:0] CRFS_ST_WARN = 2'h1;
	localparam logic [1:0] CRFS_ST_ERR = 2'h2;
	localparam logic [1:0] CRFS_ST_BUS_OFF = 2'h3;

	localparam int CRFS_WARN_LIMIT = 96;
	localparam int CRFS_ERR_LIMIT = 128;
	localparam int CRFS_BUS_OFF_LIMIT = 256;
endpackage

/* rtl/crfs_state_if.sv */
// Purpose: carries live bus state codes from the encoder to the flag logic
// Assumes: single clock domain
// Notes: codes are registered at the source
`timescale 1ns/100ps
interface crfs_state_if;
	logic [1:0] rx_state;
	logic [1:0] tx_state;
	modport src (output rx_state, output tx_state);
	modport dst (input rx_state, input tx_state);
endinterface

/* rtl/crfs_state_encoder.sv */
// Purpose: maps error counters onto receiver and transmitter bus state codes
// Assumes: counters synchronous to clk_sys_i
// Notes: one cycle of latency; codes keep tracking during init mode
`timescale 1ns/100ps
module crfs_state_encoder
	import crfs_pkg::*;
#(
	parameter int RX_CNT_W = 8,
	parameter int TX_CNT_W = 9
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [RX_CNT_W-1:0] rx_err_count_i,
	input wire logic [TX_CNT_W-1:0] tx_err_count_i,
	crfs_state_if.src state_o
);
	logic [1:0] rx_q;
	logic [1:0] tx_q;
	logic [1:0] rx_d;
	logic [1:0] tx_d;
	logic bus_off;

	assign bus_off = 32'(tx_err_count_i) >= CRFS_BUS_OFF_LIMIT;

	always_comb begin
		if (bus_off) begin
			rx_d = CRFS_ST_BUS_OFF;
		end else if (tx_q == CRFS_ST_BUS_OFF) begin
			rx_d = CRFS_ST_OK;
		end else if (32'(rx_err_count_i) >= CRFS_ERR_LIMIT) begin
			rx_d = CRFS_ST_ERR;
		end else if (32'(rx_err_count_i) >= CRFS_WARN_LIMIT) begin
			rx_d = CRFS_ST_WARN;
		end else begin
			rx_d = CRFS_ST_OK;
		end
		if (bus_off) begin
			tx_d = CRFS_ST_BUS_OFF;
		end else if (32'(tx_err_count_i) >= CRFS_ERR_LIMIT) begin
			tx_d = CRFS_ST_ERR;
		end else if (32'(tx_err_count_i) >= CRFS_WARN_LIMIT) begin
			tx_d = CRFS_ST_WARN;
		end else begin
			tx_d = CRFS_ST_OK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rx_q <= CRFS_STATE_RESET;
			tx_q <= CRFS_STATE_RESET;
		end else begin
			rx_q <= rx_d;
			tx_q <= tx_d;
		end
	end

	assign state_o.rx_state = rx_q;
	assign state_o.tx_state = tx_q;
endmodule

/* rtl/crfs_flag_cell.sv */
// Purpose: one hardware-set, write-one-to-clear flag
// Assumes: set, clear and condition are single-cycle synchronous terms
// Notes: a set in the clear cycle wins so no event is lost
`timescale 1ns/100ps
module crfs_flag_cell (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic hold_i,
	input wire logic set_i,
	input wire logic clear_i,
	input wire logic cond_i,
	output logic flag_o
);
	logic flag_q;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i || hold_i) begin
			flag_q <= 1'b0;
		end else if (set_i) begin
			flag_q <= 1'b1;
		end else if (clear_i && !cond_i) begin
			flag_q <= 1'b0;
		end
	end

	assign flag_o = flag_q;
endmodule

/* rtl/crfs_top.sv */
// Purpose: receive flag register, bus state fields and interrupt requests
// Assumes: error counters, sleep mode and bus activity come from the controller core
// Notes: every access takes exactly one wait cycle on the bus
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
module crfs_top
	import crfs_pkg::*;
#(
	parameter int RX_CNT_W = 8,
	parameter int TX_CNT_W = 9
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [RX_CNT_W-1:0] rx_err_count_i,
	input wire logic [TX_CNT_W-1:0] tx_err_count_i,
	input wire logic sleep_mode_i,
	input wire logic bus_activity_i,
	output logic wake_irq_o,
	output logic error_irq_o
);
	if (RX_CNT_W < 8 || TX_CNT_W < 9) begin : g_bad_width
		$error("counter widths too narrow for the bus state bands");
	end

	crfs_state_if live_if ();

	logic wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] enables_q;
	logic [1:0] control_q;
	logic init_ack_q;
	logic [1:0] rx_rep_q;
	logic [1:0] tx_rep_q;
	logic wake_irq_q;
	logic error_irq_q;
	logic wr_fire;
	logic lane0;
	logic init_mode;
	logic flag_writable;
	logic state_change;
	logic wake_cond;
	logic [CRFS_NUM_FLAGS-1:0] flags;
	logic [CRFS_NUM_FLAGS-1:0] flag_set;
	logic [CRFS_NUM_FLAGS-1:0] flag_cond;
	logic [CRFS_NUM_FLAGS-1:0] flag_clr;
	logic [7:0] flags_byte;

	crfs_state_encoder #(
		.RX_CNT_W(RX_CNT_W),
		.TX_CNT_W(TX_CNT_W)
	) u_encoder (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.rx_err_count_i(rx_err_count_i),
		.tx_err_count_i(tx_err_count_i),
		.state_o(live_if)
	);

	// write lands on the edge where waitrequest is seen low
	assign wr_fire = avs_write_i && !wait_q;
	assign lane0 = avs_byteenable_i[0];

	// init request bit and its acknowledge both high is init mode
	assign init_mode = control_q[CRFS_CTL_INIT_BIT] && init_ack_q;
	assign flag_writable = !control_q[CRFS_CTL_INIT_BIT] && !init_ack_q;

	assign wake_cond = sleep_mode_i && bus_activity_i && control_q[CRFS_CTL_WAKE_EN_BIT];
	assign state_change = !flags[0] &&
		(live_if.rx_state != rx_rep_q || live_if.tx_state != tx_rep_q);

	assign flag_set[1] = wake_cond;
	assign flag_cond[1] = wake_cond;
	assign flag_set[0] = state_change;
	assign flag_cond[0] = state_change;

	genvar gi;
	generate
		for (gi = 0; gi < CRFS_NUM_FLAGS; gi++) begin : g_flag
			assign flag_clr[gi] = wr_fire && lane0 && flag_writable &&
				avs_address_i == CRFS_OFF_FLAGS &&
				avs_writedata_i[CRFS_CHANGE_BIT + gi];
			crfs_flag_cell u_cell (
				.clk_sys_i(clk_sys_i),
				.reset_i(reset_i),
				.hold_i(init_mode),
				.set_i(flag_set[gi]),
				.clear_i(flag_clr[gi]),
				.cond_i(flag_cond[gi]),
				.flag_o(flags[gi])
			);
		end
	endgenerate

	// fields track only when no change pending
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rx_rep_q <= CRFS_STATE_RESET;
			tx_rep_q <= CRFS_STATE_RESET;
		end else if (!flags[0]) begin
			rx_rep_q <= live_if.rx_state;
			tx_rep_q <= live_if.tx_state;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			enables_q <= CRFS_ENABLES_RESET;
		end else if (wr_fire && lane0 && avs_address_i == CRFS_OFF_ENABLES) begin
			enables_q <= avs_writedata_i[CRFS_WAKE_BIT:CRFS_CHANGE_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			control_q <= CRFS_CONTROL_RESET;
		end else if (wr_fire && lane0 && avs_address_i == CRFS_OFF_CONTROL) begin
			control_q <= avs_writedata_i[1:0];
		end
	end

	// acknowledge follows the request one cycle later
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			init_ack_q <= 1'b0;
		end else begin
			init_ack_q <= control_q[CRFS_CTL_INIT_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wake_irq_q <= 1'b0;
			error_irq_q <= 1'b0;
		end else begin
			wake_irq_q <= flags[1] && enables_q[1];
			error_irq_q <= flags[0] && enables_q[0];
		end
	end

	always_comb begin
		flags_byte = 8'h00;
		flags_byte[CRFS_WAKE_BIT] = flags[1];
		flags_byte[CRFS_CHANGE_BIT] = flags[0];
		flags_byte[CRFS_RX_LSB +: 2] = rx_rep_q;
		flags_byte[CRFS_TX_LSB +: 2] = tx_rep_q;
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (avs_address_i)
			CRFS_OFF_FLAGS: begin
				rdata_d[7:0] = flags_byte;
			end
			CRFS_OFF_ENABLES: begin
				rdata_d[CRFS_WAKE_BIT:CRFS_CHANGE_BIT] = enables_q;
			end
			CRFS_OFF_CONTROL: begin
				rdata_d[1:0] = control_q;
			end
			CRFS_OFF_STATUS: begin
				rdata_d[CRFS_STS_ACK_BIT] = init_ack_q;
				rdata_d[CRFS_STS_SLEEP_BIT] = sleep_mode_i;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// one wait cycle per access keeps read data registered
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !((avs_read_i || avs_write_i) && wait_q);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_i && wait_q) begin
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign wake_irq_o = wake_irq_q;
	assign error_irq_o = error_irq_q;
endmodule

/* dv/crfs_properties.sv */
// Purpose: port checker of the receive flag block
// Assumes: one wait cycle per access
// Notes: enables and init request shadowed from writes
`timescale 1ns/100ps
module crfs_properties
	import crfs_pkg::*;
#(
	parameter int RX_CNT_W = 8,
	parameter int TX_CNT_W = 9
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [RX_CNT_W-1:0] rx_err_count_i,
	input wire logic [TX_CNT_W-1:0] tx_err_count_i,
	input wire logic sleep_mode_i,
	input wire logic bus_activity_i,
	input wire logic wake_irq_o,
	input wire logic error_irq_o
);
	logic [1:0] en_q;
	logic init_q;
	logic acc;
	assign acc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			en_q <= 2'h0;
		end else if (acc && avs_address_i == CRFS_OFF_ENABLES) begin
			en_q <= avs_writedata_i[7:6];
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			init_q <= 1'h0;
		end else if (acc && avs_address_i == CRFS_OFF_CONTROL) begin
			init_q <= avs_writedata_i[0];
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence s_rd_ans;
		avs_read_i && !avs_waitrequest_o;
	endsequence
	// six cycles covers request, acknowledge and the irq register
	sequence s_init_held;
		init_q [*6];
	endsequence
	a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low too long");
	a_read_hold: assert property (!$past(avs_read_i && avs_waitrequest_o)
		|-> $stable(avs_readdata_o)) else $error("read data moved");
	a_unmapped_zero: assert property (s_rd_ans ##0 avs_address_i[1:0] != 2'h0
		|-> avs_readdata_o == 32'h0) else $error("unmapped not zero");
	a_spare_bits_zero: assert property (
		s_rd_ans ##0 avs_address_i == CRFS_OFF_FLAGS |-> avs_readdata_o[1:0] == 2'h0)
		else $error("spare bits set");
	a_wake_irq_mask: assert property (!$past(en_q[1]) |-> !wake_irq_o)
		else $error("wake irq unmasked");
	a_err_irq_mask: assert property (!$past(en_q[0]) |-> !error_irq_o)
		else $error("error irq unmasked");
	a_init_irq_off: assert property (
		s_init_held |-> !wake_irq_o && !error_irq_o) else $error("irq in init");
	a_init_flags_zero: assert property (
		s_init_held ##0 s_rd_ans ##0 avs_address_i == CRFS_OFF_FLAGS
		|-> avs_readdata_o[7:6] == 2'h0) else $error("flag in init");
endmodule
bind crfs_top crfs_properties #(.RX_CNT_W(RX_CNT_W), .TX_CNT_W(TX_CNT_W)) i_props (.*);

/* dv/crfs_can_node.sv */
// Purpose: far side node driving error counters and bus activity
// Assumes: counters step one a cycle or jump at once
// Notes: slow stepping crosses every band on the way
`timescale 1ns/100ps
module crfs_can_node #(
	parameter int RW = 8,
	parameter int TW = 9
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic fast_i,
	input wire logic [RW-1:0] rx_tgt_i,
	input wire logic [TW-1:0] tx_tgt_i,
	input wire logic wake_i,
	output logic [RW-1:0] rx_err_count_o,
	output logic [TW-1:0] tx_err_count_o,
	output logic bus_activity_o
);
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || fast_i) begin
			rx_err_count_o <= reset_i ? '0 : rx_tgt_i;
			tx_err_count_o <= reset_i ? '0 : tx_tgt_i;
		end else begin
			rx_err_count_o <= rx_err_count_o + RW'(rx_tgt_i > rx_err_count_o)
				- RW'(rx_tgt_i < rx_err_count_o);
			tx_err_count_o <= tx_err_count_o + TW'(tx_tgt_i > tx_err_count_o)
				- TW'(tx_tgt_i < tx_err_count_o);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		bus_activity_o <= wake_i && !reset_i;
	end
endmodule

/* dv/tb.sv */
// Purpose: self-checking bench of the receive flag block
// Assumes: one wait cycle per access
// Notes: counters come from the node model
`timescale 1ns/100ps
module tb;
	import crfs_pkg::*;
	logic clk, rst, rd, wr, slp, fast, wk, wq, wirq, eirq, act;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, r, v;
	logic [7:0] rxt, rxc, fe;
	logic [8:0] txt, txc;
	int error_cnt = 0;
	int compares = 0;
	int seed = 52865;
	crfs_top i_dut (.clk_sys_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wq), .rx_err_count_i(rxc),
		.tx_err_count_i(txc), .sleep_mode_i(slp), .bus_activity_i(act),
		.wake_irq_o(wirq), .error_irq_o(eirq));
	crfs_can_node i_node (.clk_sys_i(clk), .reset_i(rst), .fast_i(fast), .rx_tgt_i(rxt),
		.tx_tgt_i(txt), .wake_i(wk), .rx_err_count_o(rxc), .tx_err_count_o(txc),
		.bus_activity_o(act));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic end_of_test;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= {24'h0, d};
		@(posedge clk);
		while (wq !== 1'b0) begin
			n++;
			if (n > 20) begin
				error_cnt++;
				end_of_test();
			end
			@(posedge clk);
		end
		r = rdata;
		wr <= 0;
		rd <= 0;
		@(posedge clk);
	endtask
	function automatic logic [1:0] code(input int c);
		return c >= CRFS_ERR_LIMIT ? CRFS_ST_ERR : c >= CRFS_WARN_LIMIT ? CRFS_ST_WARN : CRFS_ST_OK;
	endfunction
	task automatic flags(input logic [7:0] e);
		bus(0, CRFS_OFF_FLAGS, 0);
		check("flags", r, {24'h0, e});
	endtask
	task automatic go(input logic [7:0] rx, input logic [8:0] tx, input int w);
		rxt <= rx;
		txt <= tx;
		repeat (w) @(posedge clk);
	endtask
	initial begin
		{rst, rd, wr, addr, wdata, slp, fast, wk, rxt, txt} = 0;
		rst = 1;
		fast = 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		flags(8'h00);
		bus(0, 4'h2, 0);
		check("unmapped", r, 0);
		go(96, 0, 4);
		flags(8'h50);
		go(130, 0, 4);
		flags(8'h50);
		// zeros to flags, ones to read-only and spare bits
		bus(1, CRFS_OFF_FLAGS, 8'h3f);
		flags(8'h50);
		bus(1, CRFS_OFF_ENABLES, 8'hc0);
		@(posedge clk);
		check("error irq", eirq, 1);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		flags(8'h60);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		flags(8'h20);
		check("error irq", eirq, 0);
		$display("state tests done");
		go(130, 300, 4);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		flags(8'h3c);
		go(130, 0, 4);
		flags(8'h40);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		$display("bus-off tests done");
		// slow runs cross bands, so clear twice once counters settle
		for (int i = 0; i < 20; i++) begin
			v = $random(seed);
			fast <= v[20];
			go(v[7:0], {2'h0, v[14:8]}, 260);
			bus(1, CRFS_OFF_FLAGS, 8'h40);
			bus(1, CRFS_OFF_FLAGS, 8'h40);
			fe = {2'h0, code(v[7:0]), code(v[14:8]), 2'h0};
			flags(fe);
		end
		$display("random tests done");
		// known rx error band with jumps, so the init exit below sees a real change
		fast <= 1;
		go(130, 0, 4);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		fe = 8'h20;
		flags(fe);
		slp <= 1;
		bus(1, CRFS_OFF_CONTROL, 8'h02);
		wk <= 1;
		repeat (3) @(posedge clk);
		bus(1, CRFS_OFF_FLAGS, 8'h80);
		flags(8'h80 | fe);
		check("wake irq", wirq, 1);
		wk <= 0;
		@(posedge clk);
		bus(1, CRFS_OFF_FLAGS, 8'h80);
		flags(fe);
		check("wake irq", wirq, 0);
		wk <= 1;
		repeat (3) @(posedge clk);
		bus(1, CRFS_OFF_CONTROL, 8'h01);
		wk <= 0;
		repeat (3) @(posedge clk);
		flags(fe);
		check("wake irq", wirq, 0);
		bus(1, CRFS_OFF_CONTROL, 8'h00);
		go(0, 0, 4);
		flags(8'h40);
		bus(1, CRFS_OFF_FLAGS, 8'h40);
		flags(8'h00);
		$display("wake and init tests done");
		end_of_test();
	end
endmodule
